// *** pkg/cpo_defines.svh ***
// Summary of operation
// - The carrier frequency word is 32 bits from four byte registers, the highest address holding the top byte.
// - Writing a frequency word byte only stores it; the active frequency does not change.
// - The stored word moves to the active oscillator only on a serial update from the control register or a frameUpdate pulse.
// - The frequency word is a signed two's complement value.
// - On reset the top frequency byte is 0x10 and the other bytes are zero.
// - The 16-bit start phase from the low and high bytes loads the oscillator phase on every phase restart.
// - The start phase is two's complement over a full circle, 0.0055 degrees per step.
// - The quadrature skew is 13-bit two's complement from eight low and five high bits, applied between I and Q.
// - The skew spans about plus or minus 14 degrees at 0.0035 degrees per count.
// - Four separate sleep bits power down data lines zero to three, each only its own line.
// - A 16-bit I-channel DC shift from a low and high byte is added to every I sample.
// - Software asks for a frequency update by a request bit; a read-only ack shows when the word is active.
// - Software asks for a phase restart by a request bit; the phase restarts and a read-only ack reports it.
`ifndef CPO_DEFINES_SVH
`define CPO_DEFINES_SVH
`define CPO_ADDR_CTRL 8'h30
`define CPO_ADDR_FW0 8'h31
`define CPO_ADDR_FW1 8'h32
`define CPO_ADDR_FW2 8'h33
`define CPO_ADDR_FW3 8'h34
`define CPO_ADDR_PH_LO 8'h35
`define CPO_ADDR_PH_HI 8'h36
`define CPO_ADDR_SK_LO 8'h37
`define CPO_ADDR_SK_HI 8'h38
`define CPO_ADDR_SLEEP 8'h39
`define CPO_ADDR_DC_LO 8'h3b
`define CPO_ADDR_DC_HI 8'h3c
`define CPO_RST_FW3 8'h10
`define CPO_RST_BYTE 8'h00
`define CPO_BIT_FREQ_REQ 0
`define CPO_BIT_FREQ_ACK 1
`define CPO_BIT_PH_REQ 4
`define CPO_BIT_PH_ACK 5
`define CPO_BIT_FRAME_ACK 6
`define CPO_SKEW_HI_W 5
`define CPO_SLEEP_W 4
`endif

// *** pkg/cpo_pkg.sv ***
package cpo_pkg;
    typedef enum logic [1:0] {
        CPO_IDLE = 2'b00,
        CPO_APPLY = 2'b01,
        CPO_ACKED = 2'b10
    } cpo_hs_t;

    typedef struct packed {
        logic [31:0] freqShadow;
        logic [15:0] phaseStart;
        logic [12:0] skew;
        logic [3:0] sleep;
        logic [15:0] dcShift;
        logic freqReq;
        logic phaseReq;
        logic frameAck;
        cpo_hs_t freqSt;
        cpo_hs_t phaseSt;
        logic [31:0] freqActive;
        logic [7:0] rdata;
    } cpo_state_t;
endpackage

// *** rtl/cpo_dc_adder.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpo_dc_adder
    import cpo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [15:0] sampleIn,
    input wire logic [15:0] dcShift,
    output logic [15:0] sampleOut
);
    typedef struct packed {
        logic [15:0] sum;
    } cpo_add_t;

    cpo_add_t a_q, a_d;

    // Wraps modulo 2^16; saturation is left to the converter path
    always_comb begin
        a_d = a_q;
        a_d.sum = 16'(sampleIn + dcShift);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_q <= '0;
        end else if (ce) begin
            a_q <= a_d;
        end
    end

    assign sampleOut = a_q.sum;
endmodule // cpo_dc_adder
`default_nettype wire

// *** rtl/cpo_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpo_defines.svh"
module cpo_regs
    import cpo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic regWe,
    input wire logic regRe,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic frameUpdate,
    input wire logic [15:0] iSampleIn,
    output logic [15:0] iSampleOut,
    output logic [31:0] carrierFreqWord,
    output logic [15:0] carrierStartPhase,
    output logic phaseRestart,
    output logic [12:0] quadratureSkew,
    output logic [3:0] dataLineSleep
);
    cpo_state_t s_q, s_d;

    function automatic logic [7:0] byteOf(input logic [31:0] w,
                                          input logic [1:0] i);
        byteOf = w[i*8 +: 8];
    endfunction

    function automatic logic isWr(input logic we, input logic [7:0] a,
                                  input logic [7:0] t);
        isWr = we && (a == t);
    endfunction

    always_comb begin
        s_d = s_q;
        if (isWr(regWe, regAddr, `CPO_ADDR_FW0))
            s_d.freqShadow[7:0] = regWdata;
        if (isWr(regWe, regAddr, `CPO_ADDR_FW1))
            s_d.freqShadow[15:8] = regWdata;
        if (isWr(regWe, regAddr, `CPO_ADDR_FW2))
            s_d.freqShadow[23:16] = regWdata;
        if (isWr(regWe, regAddr, `CPO_ADDR_FW3))
            s_d.freqShadow[31:24] = regWdata;
        if (isWr(regWe, regAddr, `CPO_ADDR_PH_LO))
            s_d.phaseStart[7:0] = regWdata;
        if (isWr(regWe, regAddr, `CPO_ADDR_PH_HI))
            s_d.phaseStart[15:8] = regWdata;
        if (isWr(regWe, regAddr, `CPO_ADDR_SK_LO))
            s_d.skew[7:0] = regWdata;
        if (isWr(regWe, regAddr, `CPO_ADDR_SK_HI))
            s_d.skew[12:8] = regWdata[`CPO_SKEW_HI_W-1:0];
        if (isWr(regWe, regAddr, `CPO_ADDR_SLEEP))
            s_d.sleep = regWdata[`CPO_SLEEP_W-1:0];
        if (isWr(regWe, regAddr, `CPO_ADDR_DC_LO))
            s_d.dcShift[7:0] = regWdata;
        if (isWr(regWe, regAddr, `CPO_ADDR_DC_HI))
            s_d.dcShift[15:8] = regWdata;
        if (isWr(regWe, regAddr, `CPO_ADDR_CTRL)) begin
            s_d.freqReq = regWdata[`CPO_BIT_FREQ_REQ];
            s_d.phaseReq = regWdata[`CPO_BIT_PH_REQ];
        end
        // Request is a level; ack follows it so software can poll
        case (s_q.freqSt)
            CPO_IDLE: begin
                if (s_q.freqReq) begin
                    s_d.freqSt = CPO_APPLY;
                end
            end
            CPO_APPLY: begin
                s_d.freqActive = s_q.freqShadow;
                s_d.freqSt = CPO_ACKED;
            end
            CPO_ACKED: begin
                if (!s_q.freqReq) begin
                    s_d.freqSt = CPO_IDLE;
                end
            end
            default: s_d.freqSt = CPO_IDLE;
        endcase
        // Frame update loads at once and sets frameAck, cleared by the next control write
        if (frameUpdate) begin
            s_d.freqActive = s_q.freqShadow;
            s_d.frameAck = 1'b1;
        end else if (isWr(regWe, regAddr, `CPO_ADDR_CTRL)) begin
            s_d.frameAck = 1'b0;
        end
        case (s_q.phaseSt)
            CPO_IDLE: begin
                if (s_q.phaseReq) begin
                    s_d.phaseSt = CPO_APPLY;
                end
            end
            CPO_APPLY: s_d.phaseSt = CPO_ACKED;
            CPO_ACKED: begin
                if (!s_q.phaseReq) begin
                    s_d.phaseSt = CPO_IDLE;
                end
            end
            default: s_d.phaseSt = CPO_IDLE;
        endcase
        s_d.rdata = 8'h00;
        if (regRe) begin
            case (regAddr)
                `CPO_ADDR_CTRL: begin
                    s_d.rdata[`CPO_BIT_FREQ_REQ] = s_q.freqReq;
                    s_d.rdata[`CPO_BIT_FREQ_ACK] =
                        (s_q.freqSt == CPO_ACKED);
                    s_d.rdata[`CPO_BIT_PH_REQ] = s_q.phaseReq;
                    s_d.rdata[`CPO_BIT_PH_ACK] =
                        (s_q.phaseSt == CPO_ACKED);
                    s_d.rdata[`CPO_BIT_FRAME_ACK] = s_q.frameAck;
                end
                `CPO_ADDR_FW0: s_d.rdata = byteOf(s_q.freqShadow, 2'd0);
                `CPO_ADDR_FW1: s_d.rdata = byteOf(s_q.freqShadow, 2'd1);
                `CPO_ADDR_FW2: s_d.rdata = byteOf(s_q.freqShadow, 2'd2);
                `CPO_ADDR_FW3: s_d.rdata = byteOf(s_q.freqShadow, 2'd3);
                `CPO_ADDR_PH_LO: s_d.rdata = s_q.phaseStart[7:0];
                `CPO_ADDR_PH_HI: s_d.rdata = s_q.phaseStart[15:8];
                `CPO_ADDR_SK_LO: s_d.rdata = s_q.skew[7:0];
                `CPO_ADDR_SK_HI: s_d.rdata = {3'h0, s_q.skew[12:8]};
                `CPO_ADDR_SLEEP: s_d.rdata = {4'h0, s_q.sleep};
                `CPO_ADDR_DC_LO: s_d.rdata = s_q.dcShift[7:0];
                `CPO_ADDR_DC_HI: s_d.rdata = s_q.dcShift[15:8];
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.freqShadow <= {`CPO_RST_FW3, `CPO_RST_BYTE,
                               `CPO_RST_BYTE, `CPO_RST_BYTE};
            s_q.freqActive <= {`CPO_RST_FW3, `CPO_RST_BYTE,
                               `CPO_RST_BYTE, `CPO_RST_BYTE};
            s_q.freqSt <= CPO_IDLE;
            s_q.phaseSt <= CPO_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // Signed interpretation is for the oscillator downstream
    assign carrierFreqWord = s_q.freqActive;
    assign carrierStartPhase = s_q.phaseStart;
    assign phaseRestart = (s_q.phaseSt == CPO_APPLY);
    assign quadratureSkew = s_q.skew;
    assign dataLineSleep = s_q.sleep;
    assign regRdata = s_q.rdata;

    cpo_dc_adder i_cpo_dc_adder (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .sampleIn(iSampleIn),
        .dcShift(s_q.dcShift),
        .sampleOut(iSampleOut)
    );

    sequence freqReqRise_s;
        regWe && regAddr == `CPO_ADDR_CTRL
            && regWdata[`CPO_BIT_FREQ_REQ] && ce;
    endsequence

    shadow_isolation_a: assert property (@(posedge mclk)
        disable iff (rst)
        ce && s_q.freqSt != CPO_APPLY && !frameUpdate
        |=> $stable(s_q.freqActive))
        else $error("active word changed without update");
    apply_loads_a: assert property (@(posedge mclk)
        disable iff (rst)
        ce && s_q.freqSt == CPO_APPLY
        |=> s_q.freqActive == $past(s_q.freqShadow))
        else $error("apply did not load whole word");
    frame_load_a: assert property (@(posedge mclk)
        disable iff (rst)
        ce && frameUpdate
        |=> s_q.frameAck && carrierFreqWord == $past(s_q.freqShadow))
        else $error("frame update did not load word");
    req_ack_a: assert property (@(posedge mclk)
        disable iff (rst)
        freqReqRise_s ##1 (ce && s_q.freqSt == CPO_IDLE) ##1 ce
        |=> s_q.freqSt == CPO_ACKED)
        else $error("freq ack missing");
    restart_pulse_a: assert property (@(posedge mclk)
        disable iff (rst)
        phaseRestart && ce |=> !phaseRestart)
        else $error("phase restart not single cycle");
    sleep_write_a: assert property (@(posedge mclk)
        disable iff (rst)
        ce && regWe && regAddr == `CPO_ADDR_SLEEP
        |=> dataLineSleep == $past(regWdata[`CPO_SLEEP_W-1:0]))
        else $error("sleep bits not written");
    skew_hi_a: assert property (@(posedge mclk)
        disable iff (rst)
        ce && regWe && regAddr == `CPO_ADDR_SK_HI
        |=> quadratureSkew[12:8] == $past(regWdata[`CPO_SKEW_HI_W-1:0]))
        else $error("skew high bits wrong");
    fw3_read_a: assert property (@(posedge mclk)
        disable iff (rst)
        ce && regRe && regAddr == `CPO_ADDR_FW3
        |=> regRdata == $past(s_q.freqShadow[31:24]))
        else $error("byte readback wrong");
    dc_sum_a: assert property (@(posedge mclk)
        disable iff (rst)
        ce
        |=> iSampleOut == 16'($past(iSampleIn) + $past(s_q.dcShift)))
        else $error("dc shift sum wrong");
endmodule // cpo_regs
`default_nettype wire

// *** verif/cpo_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpo_defines.svh"
module cpo_regs_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic regWe = 1'b0;
    logic regRe = 1'b0;
    logic frameUpdate = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [15:0] iSampleIn = 16'h0000;
    logic [7:0] regRdata;
    logic [15:0] iSampleOut;
    logic [31:0] carrierFreqWord;
    logic [15:0] carrierStartPhase;
    logic phaseRestart;
    logic [12:0] quadratureSkew;
    logic [3:0] dataLineSleep;
    logic [7:0] d;
    int err_total = 0;
    int compares = 0;
    int pulses = 0;
    int pulseBase = 0;

    cpo_regs i_cpo_regs (.mclk(mclk), .rst(rst), .ce(ce), .regWe(regWe),
        .regRe(regRe), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .frameUpdate(frameUpdate),
        .iSampleIn(iSampleIn), .iSampleOut(iSampleOut),
        .carrierFreqWord(carrierFreqWord),
        .carrierStartPhase(carrierStartPhase), .phaseRestart(phaseRestart),
        .quadratureSkew(quadratureSkew), .dataLineSleep(dataLineSleep));

    always #12.5 mclk = ~mclk;

    always @(posedge mclk) begin
        if (phaseRestart === 1'b1) pulses++;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        regWe <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge mclk);
        regWe <= 1'b0;
    endtask

    // Read data is registered: sampled half a cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        regRe <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRe <= 1'b0;
        @(negedge mclk);
        v = regRdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, v});
    endtask

    task automatic settle;
        repeat (3) @(negedge mclk);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        chk("freq word", 32'h10000000, carrierFreqWord);
        for (int a = 'h30; a <= 'h3d; a++) begin
            rdc(a[7:0], (a == 'h34) ? `CPO_RST_FW3 : `CPO_RST_BYTE);
        end
        $display("test reset done");
        wr(`CPO_ADDR_FW0, 8'h78);
        wr(`CPO_ADDR_FW1, 8'h56);
        wr(`CPO_ADDR_FW2, 8'h34);
        wr(`CPO_ADDR_FW3, 8'hf2);
        settle();
        chk("held word", 32'h10000000, carrierFreqWord);
        rdc(`CPO_ADDR_FW3, 8'hf2);
        rdc(`CPO_ADDR_FW0, 8'h78);
        wr(`CPO_ADDR_CTRL, 8'h01);
        d = 8'h00;
        for (int k = 0; k < 8 && !d[1]; k++) rd(`CPO_ADDR_CTRL, d);
        chk("ctrl ack", 32'h03, {24'h0, d});
        chk("signed word", 32'hf2345678, carrierFreqWord);
        wr(`CPO_ADDR_CTRL, 8'h00);
        rdc(`CPO_ADDR_CTRL, 8'h00);
        $display("test freq apply done");
        wr(`CPO_ADDR_FW0, 8'h11);
        @(posedge mclk);
        frameUpdate <= 1'b1;
        @(posedge mclk);
        frameUpdate <= 1'b0;
        settle();
        chk("frame word", 32'hf2345611, carrierFreqWord);
        rdc(`CPO_ADDR_CTRL, 8'h40);
        $display("test frame update done");
        wr(`CPO_ADDR_PH_LO, 8'h34);
        wr(`CPO_ADDR_PH_HI, 8'h12);
        settle();
        chk("start phase", 32'h1234, {16'h0, carrierStartPhase});
        pulseBase = pulses;
        wr(`CPO_ADDR_CTRL, 8'h10);
        repeat (10) @(posedge mclk);
        chk("restart pulses", 32'h1, pulses - pulseBase);
        rdc(`CPO_ADDR_CTRL, 8'h30);
        wr(`CPO_ADDR_CTRL, 8'h00);
        rdc(`CPO_ADDR_CTRL, 8'h00);
        $display("test phase restart done");
        wr(`CPO_ADDR_SK_LO, 8'hff);
        wr(`CPO_ADDR_SK_HI, 8'hff);
        settle();
        chk("skew", 32'h1fff, {19'h0, quadratureSkew});
        rdc(`CPO_ADDR_SK_HI, 8'h1f);
        wr(`CPO_ADDR_SK_HI, 8'h10);
        settle();
        chk("skew neg", 32'h10ff, {19'h0, quadratureSkew});
        for (int n = 0; n < 4; n++) begin
            wr(`CPO_ADDR_SLEEP, 8'h01 << n);
            settle();
            chk("sleep", 32'h1 << n, {28'h0, dataLineSleep});
        end
        wr(`CPO_ADDR_SLEEP, 8'hff);
        rdc(`CPO_ADDR_SLEEP, 8'h0f);
        $display("test skew sleep done");
        wr(`CPO_ADDR_DC_LO, 8'h01);
        wr(`CPO_ADDR_DC_HI, 8'h80);
        @(posedge mclk);
        iSampleIn <= 16'h7fff;
        settle();
        chk("dc wrap", 32'h0, {16'h0, iSampleOut});
        @(posedge mclk);
        iSampleIn <= 16'h1000;
        settle();
        chk("dc add", 32'h9001, {16'h0, iSampleOut});
        rdc(`CPO_ADDR_DC_HI, 8'h80);
        $display("test dc shift done");
        // Unmapped hole must neither store nor answer
        wr(8'h3a, 8'h55);
        rdc(8'h3a, 8'h00);
        @(posedge mclk);
        ce <= 1'b0;
        wr(`CPO_ADDR_SLEEP, 8'h05);
        @(posedge mclk);
        ce <= 1'b1;
        rdc(`CPO_ADDR_SLEEP, 8'h0f);
        $display("test refusal done");
        wrap_up();
    end
endmodule // cpo_regs_tb
`default_nettype wire
